// [sim/tb.sv]
// Bench: register access, a general call write and a short read.
`timescale 1ns/100ps
module tb
    import tdp_pkg::*;
;
    logic        REF_CLK, RST, CE, HSEL, HWRITE, LINK_CLK, HREADY;
    logic [31:0] HADDR, HWDATA, HRDATA, v;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic        HREADYOUT, HRESP, SCL_O, SCL_OE, SDA_O, SDA_OE;
    logic        t_sda_oe, t_scl_oe, stretch;
    logic [3:0]  nbits;
    int          error_cnt = 0;
    int          checked = 0;
    // Open-drain lines with pull-ups.
    wire         scl_w = !(SCL_OE || t_scl_oe);
    wire         sda_w = !(SDA_OE || t_sda_oe);
    assign HREADY = HREADYOUT;
    initial begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    initial begin
        LINK_CLK = 1'b0;
        #7;
        forever #15 LINK_CLK = ~LINK_CLK;
    end
    tdp_top DUT (.REF_CLK(REF_CLK), .RST(RST), .CE(CE), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINK_CLK(LINK_CLK),
        .SCL_I(scl_w), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda_w),
        .SDA_O(SDA_O), .SDA_OE(SDA_OE));
    tdp_target u_tgt (.scl(scl_w), .sda(sda_w), .nbits(nbits),
        .tx(8'h0b), .stretch(stretch), .sda_oe(t_sda_oe),
        .scl_oe(t_scl_oe));
    // One single transfer; read data lands in v.
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h000000, a};
        HWRITE <= wr;
        HTRANS <= 2'h2;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        v = HRDATA;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, v);
    endtask
    // Polls until the pending stop has been carried out.
    task wait_idle;
        for (int i = 0; i < 2000; i++) begin
            repeat (200) @(posedge REF_CLK);
            bus(1'b0, OFS_MODE, 32'h0);
            if (v[11] === 1'b0) break;
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog against a hung transfer.
    initial begin
        repeat (95000) @(posedge REF_CLK);
        error_cnt++;
        wrap_up;
    end
    // Main sequence.
    initial begin
        RST <= 1'b1;
        CE <= 1'b1;
        HSEL <= 1'b0;
        HADDR <= 32'h0;
        HTRANS <= 2'h0;
        HWRITE <= 1'b0;
        HSIZE <= 3'h2;
        HWDATA <= 32'h0;
        nbits <= 4'h8;
        stretch <= 1'b0;
        repeat (3) @(posedge LINK_CLK);
        @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        rdc(OFS_MODE, 32'h0, "mode reset");
        bus(1'b1, OFS_COUNT, 32'hffff_0001);
        rdc(OFS_COUNT, 32'h1, "count mask");
        bus(1'b1, OFS_MODE, 32'hffff_d0df);
        rdc(OFS_MODE, 32'h0000_c0df, "mode fields");
        bus(1'b1, OFS_MODE, 32'h0);
        bus(1'b1, 8'h18, 32'hffff_ffff);
        rdc(8'h18, 32'h0, "hole");
        $display("test registers done");
        bus(1'b1, OFS_TADDR, 32'hffff_fb80);
        rdc(OFS_TADDR, 32'h380, "address mask");
        bus(1'b1, OFS_TXBUF, 32'hffff_ffa6);
        rdc(OFS_TXBUF, 32'ha6, "tx buffer");
        rdc(OFS_STATUS, 32'h1, "status tx");
        bus(1'b1, OFS_MODE, 32'h2e20);
        wait_idle;
        rdc(OFS_MODE, 32'h0220, "mode after stop");
        rdc(OFS_COUNT, 32'h1, "count kept");
        rdc(OFS_STATUS, 32'h0, "status idle");
        chk("bytes", 32'h2, u_tgt.got.size());
        chk("addr byte", 32'h0, {24'h0, u_tgt.got[0]});
        chk("data byte", 32'ha6, {24'h0, u_tgt.got[1]});
        chk("stops", 32'h1, u_tgt.stops);
        $display("test write done");
        nbits <= 4'h4;
        stretch <= 1'b1;
        bus(1'b1, OFS_TADDR, 32'h12b);
        bus(1'b1, OFS_MODE, 32'h2c24);
        wait_idle;
        rdc(OFS_MODE, 32'h0024, "mode after read");
        rdc(OFS_STATUS, 32'h2, "status rx");
        bus(1'b0, OFS_RXBUF, 32'h0);
        chk("rx word", 32'hb, {28'h0, v[3:0]});
        chk("read addr", 32'h57, {24'h0, u_tgt.got[2]});
        chk("stops", 32'h2, u_tgt.stops);
        $display("test read done");
        wrap_up;
    end
endmodule

// [sim/tdp_target.sv]
// Behavioural bus target: acks, records bytes, answers reads, stretches.
`timescale 1ns/100ps
module tdp_target (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [3:0] nbits,
    input  wire logic [7:0] tx,
    input  wire logic       stretch,
    output logic            sda_oe,
    output logic            scl_oe
);
    logic [7:0] sh;
    logic [7:0] got[$];
    logic [3:0] w;
    logic       rd = 1'b0;
    logic       in_frame = 1'b0;
    int         bitn = 0;
    int         byten = 0;
    int         stops = 0;
    // The first byte, the address, is always eight bits wide; later bytes take nbits.
    assign w = (byten == 0) ? 4'h8 : nbits;
    initial begin
        sda_oe = 1'b0;
        scl_oe = 1'b0;
    end
    // Data falling while the clock is high opens a frame.
    always @(negedge sda) if (scl) begin
        bitn = 0;
        byten = 0;
        rd = 1'b0;
        sda_oe = 1'b0;
        in_frame = 1'b1;
    end
    // Data rising while the clock is high closes an open frame only.
    always @(posedge sda) if (scl === 1'b1 && in_frame) begin
        stops++;
        in_frame = 1'b0;
    end
    // Bits are taken on the rising clock; the last clock is the ack.
    always @(posedge scl) begin
        if (bitn < int'(w)) begin
            sh = {sh[6:0], sda};
            bitn++;
        end else begin
            if (!(rd && byten > 0)) got.push_back(sh);
            if (byten == 0) rd = sh[0];
            bitn = 0;
            byten++;
        end
    end
    // Data and ack change while the clock is low; with stretch set the clock is then held.
    always @(negedge scl) begin
        if (bitn == int'(w)) sda_oe = !(rd && byten > 0);
        else if (rd && byten > 0) sda_oe = !tx[int'(w) - 1 - bitn];
        else sda_oe = 1'b0;
        if (stretch) begin
            scl_oe = 1'b1;
            #6000 scl_oe = 1'b0;
        end
    end
endmodule

// [sim/tdp_top_asserts.sv]
// Concurrent checks on the register bus and the serial line drivers.
`timescale 1ns/100ps
module tdp_top_asserts
    import tdp_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        CE,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        LINK_CLK,
    input wire logic        SCL_OE,
    input wire logic        SDA_OE,
    input wire logic        SCL_O,
    input wire logic        SDA_O
);
    // Taken address phases and the one-wait read answer.
    sequence s_go;
        HSEL && HREADY && HTRANS[1] && CE;
    endsequence
    sequence s_ans;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    property p_rd_wait;
        @(posedge REF_CLK) disable iff (RST) s_go ##0 !HWRITE |=> s_ans;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait");
    property p_wr_ok;
        @(posedge REF_CLK) disable iff (RST)
        s_go ##0 HWRITE |=> HREADYOUT && !HRESP;
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("write answer");
    property p_cnt_hi;
        @(posedge REF_CLK) disable iff (RST) s_go ##0 !HWRITE &&
        HADDR[7:0] == OFS_COUNT |=> ##1 HRDATA[31:16] == 16'h0000;
    endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("count upper");
    property p_mode_hi;
        @(posedge REF_CLK) disable iff (RST) s_go ##0 !HWRITE &&
        HADDR[7:0] == OFS_MODE |=> ##1
        (HRDATA[31:16] == 16'h0000 && !HRDATA[12]);
    endproperty
    a_mode_hi: assert property (p_mode_hi) else $error("mode upper");
    property p_rx_hi;
        @(posedge REF_CLK) disable iff (RST) s_go ##0 !HWRITE &&
        HADDR[7:0] == OFS_RXBUF |=> ##1 HRDATA[31:8] == 24'h000000;
    endproperty
    a_rx_hi: assert property (p_rx_hi) else $error("rx upper");
    property p_ta_hi;
        @(posedge REF_CLK) disable iff (RST) s_go ##0 !HWRITE &&
        HADDR[7:0] == OFS_TADDR |=> ##1 HRDATA[31:10] == 22'h000000;
    endproperty
    a_ta_hi: assert property (p_ta_hi) else $error("addr upper");
    // A start holds data low until the clock is pulled low.
    property p_start;
        @(posedge LINK_CLK) disable iff (RST) $rose(SDA_OE) && !SCL_OE
        |-> SDA_OE throughout (##[1:400] SCL_OE);
    endproperty
    a_start: assert property (p_start) else $error("start shape");
    // After a stop both lines stay released for eight link clocks.
    property p_stop;
        @(posedge LINK_CLK) disable iff (RST) $fell(SDA_OE) && !SCL_OE
        |=> (!SCL_OE && !SDA_OE) [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("stop shape");
    // Open-drain outputs never drive a high level onto the lines.
    property p_lvl;
        @(posedge LINK_CLK) disable iff (RST) !SCL_O && !SDA_O;
    endproperty
    a_lvl: assert property (p_lvl) else $error("line level");
endmodule

bind tdp_top tdp_top_asserts u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINK_CLK(LINK_CLK),
    .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .SCL_O(SCL_O), .SDA_O(SDA_O)
);

// [src/tdp_pkg.sv]
// Shared constants, register layout and state types of the transfer data path.
package tdp_pkg;

    // Byte offsets of the registers on the bus.
    localparam logic [7:0] OFS_COUNT  = 8'h00;
    localparam logic [7:0] OFS_RXBUF  = 8'h04;
    localparam logic [7:0] OFS_TADDR  = 8'h08;
    localparam logic [7:0] OFS_TXBUF  = 8'h0c;
    localparam logic [7:0] OFS_MODE   = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Reset values and fixed encodings.
    localparam logic [15:0] MODE_RST       = 16'h0000;
    localparam logic [16:0] COUNT_FULL     = 17'h10000;
    localparam logic [4:0]  TEN_BIT_PREFIX = 5'h1e;
    localparam logic [3:0]  FULL_WIDTH     = 4'h8;

    // Serial bit timing: one quarter of a bit period, in link clocks.
    localparam int QTR_TIME_NS = 2500;
    localparam int LINK_CLK_NS = 30;
    localparam int QTR_CYCLES  = (QTR_TIME_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam logic [7:0] QTR_RELOAD = 8'(QTR_CYCLES - 1);

    // Mode control register layout, bit 15 down to bit 0.
    typedef struct packed {
        logic       force_nack;
        logic       run_free;
        logic       start_request;
        logic       rsvd12;
        logic       stop_request;
        logic       master_select;
        logic       transmit_select;
        logic       ten_bit_addr_select;
        logic       repeat_mode_select;
        logic       loopback_select;
        logic       reset_release;
        logic       start_byte_select;
        logic       free_format_select;
        logic [2:0] bit_count_field;
    } tdp_mode_t;

    // Transfer set-up handed from the register side to the link side.
    typedef struct packed {
        logic [9:0]  addr;
        logic        ten_bit;
        logic        transmit;
        logic        free_fmt;
        logic        repeat_mode;
        logic [2:0]  bit_count;
        logic [15:0] count;
    } tdp_cmd_t;

    // Levels passed into the link domain.
    typedef struct packed {
        logic cmd;
        logic txack;
        logic stop;
        logic nack;
        logic run;
        logic rst;
        logic ce;
        logic sda;
        logic scl;
    } tdp_lin_t;

    // Levels passed into the register domain.
    typedef struct packed {
        logic start_done;
        logic stop_done;
        logic tx_req;
        logic rx_tog;
        logic nack_done;
        logic busy;
    } tdp_bin_t;

    typedef enum logic [2:0] {
        L_IDLE, L_START, L_NEXT, L_WTX, L_BIT, L_ACK, L_HOLD, L_STOP
    } tdp_lstate_t;

endpackage

// [src/tdp_top.sv]
// Register file and serial bit engine of the two-wire transfer data path.
//
// Functional notes
// - Written count is copied to an internal counter, decremented per data word.
// - With stop pending, a STOP ends the transfer when the counter hits zero.
// - Count zero loads 65536; other values load themselves.
// - Count governs only non-repeat master transfers; ignored in repeat mode.
// - Count register holds 16 bits; upper bits read zero, writes ignored.
// - Received bits shift in, then the whole word is copied to the buffer.
// - Short received words sit right-aligned in the receive buffer.
// - Shift registers are hidden; only the buffer registers are on the bus.
// - A written transmit word is copied into the shift register and sent.
// - Seven-bit addressing sends address bits 6-0 only.
// - Ten-bit addressing sends all address bits 9-0.
// - Address zero is a general call; nonzero addresses one target.
// - The address is sent only outside free data format.
// - Mode register bit layout fixed; all bits reset to zero.
// - Stop request clears itself after the STOP has been generated.
// - Start request clears itself after the START has been generated.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module tdp_top
    import tdp_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        LINK_CLK,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE
);

    // Register-domain state.
    typedef struct packed {
        tdp_mode_t   mode;
        logic [15:0] tcount;
        logic [9:0]  taddr;
        logic [7:0]  txb;
        logic [7:0]  txh;
        logic [7:0]  rxb;
        logic        tx_full;
        logic        rx_full;
        tdp_cmd_t    cmd;
        logic        cmd_tog;
        logic        tx_ack;
        logic        start_seen;
        logic        stop_seen;
        logic        txreq_seen;
        logic        rx_seen;
        logic        nack_seen;
        logic        dp_wr;
        logic        rd_pend;
        logic [7:0]  dp_addr;
        logic        hready;
        logic        hresp;
        logic [31:0] hrdata;
    } tdp_bus_t;

    // Link-domain state.
    typedef struct packed {
        tdp_lstate_t st;
        logic [7:0]  q;
        logic [1:0]  ph;
        logic [3:0]  nb;
        logic [7:0]  sh;
        logic        is_rx;
        logic        is_data;
        logic        nack;
        logic        forced;
        logic [16:0] cnt;
        logic [1:0]  abytes;
        tdp_cmd_t    cfg;
        logic        cmd_seen;
        logic        txack_seen;
        logic        start_done;
        logic        stop_done;
        logic        tx_req;
        logic        rx_tog;
        logic        nack_done;
        logic        busy;
        logic [7:0]  rx_word;
        logic        scl_oe;
        logic        sda_oe;
        logic        lvl;
    } tdp_link_t;

    tdp_bus_t  bq;
    tdp_bus_t  bd;
    tdp_link_t lq;
    tdp_link_t ld;
    tdp_lin_t  li1;
    tdp_lin_t  li2;
    tdp_bin_t  bi1;
    tdp_bin_t  bi2;
    logic      tick;
    logic      stall;
    logic      sda_in;
    logic [3:0] width;

    // Bus-side read value of a register; hidden shift registers have no slot.
    function automatic logic [31:0] rd_word(input tdp_bus_t b,
                                            input logic     busy);
        logic [31:0] w;
        w = 32'h0;
        case (b.dp_addr)
            OFS_COUNT:  w = {16'h0, b.tcount};
            OFS_RXBUF:  w = {24'h0, b.rxb};
            OFS_TADDR:  w = {22'h0, b.taddr};
            OFS_TXBUF:  w = {24'h0, b.txb};
            OFS_MODE:   w = {16'h0, b.mode};
            OFS_STATUS: w = {29'h0, busy, b.rx_full, b.tx_full};
            default:    w = 32'h0;
        endcase
        return w;
    endfunction

    // Bring link-domain toggles and levels over to the register clock.
    always_ff @(posedge REF_CLK) begin
        bi1 <= {lq.start_done, lq.stop_done, lq.tx_req,
                lq.rx_tog, lq.nack_done, lq.busy};
        bi2 <= bi1;
    end

    // Register side: bus slave, register file and the handshakes.
    always_comb begin
        bd = bq;
        // Link reports: hardware clears go first so software sets win.
        if (bi2.start_done != bq.start_seen) begin
            bd.start_seen = bi2.start_done;
            bd.mode.start_request = 1'b0;
        end
        if (bi2.stop_done != bq.stop_seen) begin
            bd.stop_seen = bi2.stop_done;
            bd.mode.stop_request  = 1'b0;
            bd.mode.master_select = 1'b0;
        end
        if (bi2.nack_done != bq.nack_seen) begin
            bd.nack_seen = bi2.nack_done;
            bd.mode.force_nack = 1'b0;
        end
        // The link asks for the next byte; hand over a stable copy.
        if (bi2.tx_req != bq.txreq_seen && bq.tx_full) begin
            bd.txreq_seen = bi2.tx_req;
            bd.txh        = bq.txb;
            bd.tx_full    = 1'b0;
            bd.tx_ack     = ~bq.tx_ack;
        end
        // Launch a master transfer once no earlier launch is outstanding.
        if (bq.mode.start_request && bq.mode.master_select
            && bq.mode.reset_release && bq.cmd_tog == bq.start_seen
            && bi2.start_done == bq.start_seen) begin
            bd.cmd.addr        = bq.taddr;
            bd.cmd.ten_bit     = bq.mode.ten_bit_addr_select;
            bd.cmd.transmit    = bq.mode.transmit_select;
            bd.cmd.free_fmt    = bq.mode.free_format_select;
            bd.cmd.repeat_mode = bq.mode.repeat_mode_select;
            bd.cmd.bit_count   = bq.mode.bit_count_field;
            bd.cmd.count       = bq.tcount;
            bd.cmd_tog         = ~bq.cmd_tog;
        end
        // Read data phase: answer one cycle after the address phase.
        bd.hready = 1'b1;
        bd.hresp  = 1'b0;
        bd.rd_pend = 1'b0;
        if (bq.rd_pend) begin
            bd.hrdata = rd_word(bq, bi2.busy);
            if (bq.dp_addr == OFS_RXBUF) begin
                bd.rx_full = 1'b0;
            end
        end
        // Write data phase: the word on the bus lands in the register.
        bd.dp_wr = 1'b0;
        if (bq.dp_wr) begin
            case (bq.dp_addr)
                OFS_COUNT: bd.tcount = HWDATA[15:0];
                OFS_TADDR: bd.taddr  = HWDATA[9:0];
                OFS_TXBUF: begin
                    bd.txb     = HWDATA[7:0];
                    bd.tx_full = 1'b1;
                end
                OFS_MODE: begin
                    bd.mode        = tdp_mode_t'(HWDATA[15:0]);
                    bd.mode.rsvd12 = 1'b0;
                end
                default: ;
            endcase
        end
        // A finished byte from the link lands in the receive buffer.
        if (bi2.rx_tog != bq.rx_seen) begin
            bd.rx_seen = bi2.rx_tog;
            bd.rxb     = lq.rx_word;
            bd.rx_full = 1'b1;
        end
        // Address phase of a new transfer.
        if (HSEL && HREADY && HTRANS[1]) begin
            bd.dp_addr = HADDR[7:0];
            bd.dp_wr   = HWRITE;
            if (!HWRITE) begin
                bd.rd_pend = 1'b1;
                bd.hready  = 1'b0;
            end
        end
    end

    // Register-domain flip-flops.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            bq        <= '0;
            bq.mode   <= MODE_RST;
            bq.hready <= 1'b1;
        end else if (CE) begin
            bq <= bd;
        end
    end

    assign HRDATA    = bq.hrdata;
    assign HREADYOUT = bq.hready;
    assign HRESP     = bq.hresp;

    // Bring register levels, reset, enable and the pins to the link clock.
    always_ff @(posedge LINK_CLK) begin
        li1 <= {bq.cmd_tog, bq.tx_ack, bq.mode.stop_request,
                bq.mode.force_nack, bq.mode.reset_release, RST, CE,
                SDA_I, SCL_I};
        li2 <= li1;
    end

    // Loopback reads back the level this end drives onto the data line.
    assign sda_in = bq.mode.loopback_select ? ~lq.sda_oe : li2.sda;

    // Bit width of one data word; zero selects a full byte.
    assign width = (lq.cfg.bit_count == 3'h0) ? FULL_WIDTH
                                              : {1'b0, lq.cfg.bit_count};

    // A target holding the clock low stretches the high quarter.
    assign stall = (lq.st == L_BIT || lq.st == L_ACK) && lq.ph == 2'h2
                   && !li2.scl;
    assign tick  = (lq.q == 8'h0) && !stall;

    // Link side: START, address, data, acknowledge and STOP sequencing.
    always_comb begin
        ld = lq;
        ld.lvl = 1'b0;
        if (!stall) begin
            ld.q = tick ? QTR_RELOAD : lq.q - 8'h01;
        end
        if (tick) begin
            ld.ph = lq.ph + 2'h1;
        end
        unique case (lq.st)
            L_IDLE, L_HOLD: begin
                ld.ph = 2'h0;
                ld.q  = QTR_RELOAD;
                if (li2.cmd != lq.cmd_seen) begin
                    ld.cmd_seen = li2.cmd;
                    ld.cfg      = bq.cmd;
                    ld.cnt = (bq.cmd.count == 16'h0) ? COUNT_FULL
                                                  : {1'b0, bq.cmd.count};
                    ld.st   = L_START;
                    ld.busy = 1'b1;
                end else if (lq.st == L_HOLD && li2.stop) begin
                    ld.st = L_STOP;
                end
            end
            L_START: if (tick) begin
                unique case (lq.ph)
                    2'h0: ld.sda_oe = 1'b0;
                    2'h1: ld.scl_oe = 1'b0;
                    2'h2: ld.sda_oe = 1'b1;
                    2'h3: begin
                        ld.scl_oe     = 1'b1;
                        ld.start_done = ~lq.start_done;
                        ld.abytes = lq.cfg.free_fmt ? 2'h0
                                  : (lq.cfg.ten_bit ? 2'h2 : 2'h1);
                        ld.st = L_NEXT;
                    end
                endcase
            end
            L_NEXT: begin
                ld.ph = 2'h0;
                ld.q  = QTR_RELOAD;
                ld.is_data = 1'b0;
                ld.is_rx   = 1'b0;
                ld.nb      = FULL_WIDTH;
                if (lq.abytes == 2'h2) begin
                    ld.sh = {TEN_BIT_PREFIX, lq.cfg.addr[9:8],
                             ~lq.cfg.transmit};
                    ld.abytes = 2'h1;
                    ld.st     = L_BIT;
                end else if (lq.abytes == 2'h1) begin
                    // Address zero forms the general call byte.
                    ld.sh = lq.cfg.ten_bit ? lq.cfg.addr[7:0]
                          : {lq.cfg.addr[6:0], ~lq.cfg.transmit};
                    ld.abytes = 2'h0;
                    ld.st     = L_BIT;
                end else if (lq.cfg.repeat_mode && li2.stop) begin
                    ld.st = L_STOP;
                end else if (!lq.cfg.repeat_mode && lq.cnt == 17'h0) begin
                    ld.st = li2.stop ? L_STOP : L_HOLD;
                end else if (lq.cfg.transmit) begin
                    ld.tx_req = ~lq.tx_req;
                    ld.st     = L_WTX;
                end else begin
                    ld.is_data = 1'b1;
                    ld.is_rx   = 1'b1;
                    ld.nb      = width;
                    ld.sh      = 8'h0;
                    ld.st      = L_BIT;
                end
            end
            L_WTX: begin
                ld.ph = 2'h0;
                ld.q  = QTR_RELOAD;
                if (li2.txack != lq.txack_seen) begin
                    ld.txack_seen = li2.txack;
                    ld.sh      = bq.txh;
                    ld.nb      = width;
                    ld.is_data = 1'b1;
                    ld.st      = L_BIT;
                end
            end
            L_BIT: if (tick) begin
                unique case (lq.ph)
                    2'h0: ld.sda_oe = lq.is_rx ? 1'b0
                                    : ~lq.sh[3'(lq.nb - 4'h1)];
                    2'h1: ld.scl_oe = 1'b0;
                    2'h2: if (lq.is_rx) begin
                        ld.sh = {lq.sh[6:0], sda_in};
                    end
                    2'h3: begin
                        ld.scl_oe = 1'b1;
                        ld.nb     = lq.nb - 4'h1;
                        if (lq.nb == 4'h1) begin
                            ld.st = L_ACK;
                        end
                    end
                endcase
            end
            L_ACK: if (tick) begin
                unique case (lq.ph)
                    2'h0: begin
                        ld.forced = lq.is_rx && li2.nack;
                        ld.nack   = li2.nack || (!lq.cfg.repeat_mode
                                              && lq.cnt == 17'h1);
                        ld.sda_oe = lq.is_rx && !ld.nack;
                    end
                    2'h1: ld.scl_oe = 1'b0;
                    2'h2: ;
                    2'h3: begin
                        ld.scl_oe = 1'b1;
                        ld.st     = L_NEXT;
                        if (lq.is_data && !lq.cfg.repeat_mode) begin
                            ld.cnt = lq.cnt - 17'h1;
                        end
                        if (lq.is_rx) begin
                            ld.rx_word = lq.sh;
                            ld.rx_tog  = ~lq.rx_tog;
                        end
                        if (lq.forced) begin
                            ld.nack_done = ~lq.nack_done;
                        end
                    end
                endcase
            end
            L_STOP: if (tick) begin
                unique case (lq.ph)
                    2'h0: ld.sda_oe = 1'b1;
                    2'h1: ld.scl_oe = 1'b0;
                    2'h2: ld.sda_oe = 1'b0;
                    2'h3: begin
                        ld.stop_done = ~lq.stop_done;
                        ld.busy      = 1'b0;
                        ld.st        = L_IDLE;
                    end
                endcase
            end
        endcase
        // Held in reset by software: release both lines and stay idle.
        if (!li2.run) begin
            ld.st     = L_IDLE;
            ld.scl_oe = 1'b0;
            ld.sda_oe = 1'b0;
            ld.busy   = 1'b0;
            ld.cmd_seen = li2.cmd;
            ld.txack_seen = li2.txack;
        end
    end

    // Link-domain flip-flops.
    always_ff @(posedge LINK_CLK) begin
        if (li2.rst) begin
            lq <= '0;
        end else if (li2.ce) begin
            lq <= ld;
        end
    end

    assign SCL_O  = lq.lvl;
    assign SCL_OE = lq.scl_oe;
    assign SDA_O  = lq.lvl;
    assign SDA_OE = lq.sda_oe;

endmodule
